// file: include/otfs_pkg.sv
/*
 * Package for the output terminal function select block: register map,
 * reset values, selection codes, timing constants and the status carrier.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package otfs_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FAST_MODE = 8'h00;
    localparam logic [7:0] OFS_SEL_BASE = 8'h04;
    localparam logic [7:0] OFS_POLARITY = 8'h14;
    localparam logic [7:0] OFS_DLY_BASE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    // Terminal order: fast switch, first relay, second relay, open collector.
    localparam int NUM_TERM = 4;
    localparam logic [15:0] RST_SEL_FAST = 16'h0000;
    localparam logic [15:0] RST_SEL_RELAY1 = 16'h0002;
    localparam logic [15:0] RST_SEL_RELAY2 = 16'h0000;
    localparam logic [15:0] RST_SEL_OC = 16'h0001;
    localparam logic [15:0] RST_FAST_MODE = 16'h0000;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [15:0] MAX_SEL_CODE = 16'h0028;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int DELAY_UNIT_MS = 100;
    localparam int CYCLE_PULSE_MS = 250;
    localparam int DELAY_UNIT_CYCLES = (CLK_HZ / 1000) * DELAY_UNIT_MS;
    localparam int CYCLE_PULSE_CYCLES = (CLK_HZ / 1000) * CYCLE_PULSE_MS;

    // ------------------------------------------------------------
    // Selection codes
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        SRC_NONE = 6'h00, SRC_FREQ_REACHED = 6'h01, SRC_FREQ_LEVEL = 6'h02,
        SRC_FAULT_STOP = 6'h03, SRC_MOTOR_OVL = 6'h04, SRC_DRIVE_OVL = 6'h05,
        SRC_ZERO_RUN = 6'h06, SRC_ZERO_ALL = 6'h07, SRC_UPPER = 6'h08,
        SRC_LOWER = 6'h09, SRC_SET_COUNT = 6'h0a, SRC_DES_COUNT = 6'h0b,
        SRC_LENGTH = 6'h0c, SRC_CYCLE_DONE = 6'h0d, SRC_RUN_TIME = 6'h0e,
        SRC_FREQ_LIMITED = 6'h0f, SRC_TORQUE_LIMITED = 6'h10, SRC_READY = 6'h11,
        SRC_RUNNING = 6'h12, SRC_ANALOG_CMP = 6'h13, SRC_UNDERVOLT = 6'h14
    } otfs_src_e;

    // Drive conditions delivered by the control logic, all active high levels
    // except cycle_done, a one-cycle event, and the two signed analog input values.
    typedef struct packed {
        logic freq_reached;
        logic frequency_level_detect;
        logic fault_stop;
        logic motor_overload_warn;
        logic drive_overload_warn;
        logic running;
        logic zero_frequency;
        logic upper_limit_reached;
        logic lower_limit_reached;
        logic set_count_reached;
        logic designated_count_reached;
        logic length_exceeded;
        logic cycle_done;
        logic run_time_exceeded;
        logic command_beyond_limit;
        logic speed_control;
        logic torque_at_limit;
        logic power_stable;
        logic fault_present;
        logic undervoltage;
        logic signed [15:0] analog_input_one;
        logic signed [15:0] analog_input_two;
    } otfs_status_s;

    // Terminal pin levels: 1 means connected to common.
    typedef struct packed {
        logic fast_output_terminal;
        logic first_relay;
        logic second_relay;
        logic open_collector_output;
    } otfs_pins_s;

endpackage

`default_nettype wire

// file: rtl/otfs_top.sv
/*
 * Output terminal function select: an APB slave holding the terminal
 * selections, polarity and delays, which routes drive conditions onto the
 * fast output terminal, two relays and an open-collector output.
 * Assumes the drive status arrives synchronous to CLOCK and that the pulse
 * train for the fast terminal is produced by the frequency scaling logic.
 */
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module otfs_top #(
    parameter int DELAY_UNIT_CYC = otfs_pkg::DELAY_UNIT_CYCLES,
    parameter int CYCLE_PULSE_CYC = otfs_pkg::CYCLE_PULSE_CYCLES
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire otfs_pkg::otfs_status_s STATUS,
    input wire logic PULSE_TRAIN,
    output otfs_pkg::otfs_pins_s PINS
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic fast_mode;
        logic [3:0][15:0] sel;
        logic [3:0] polarity;
        logic [3:0][15:0] delay;
        logic [3:0] active;
        logic [3:0][15:0] elapsed;
        logic [31:0] unit_cnt;
        logic [31:0] pulse_cnt;
        logic [31:0] rdata;
        logic err;
        logic [3:0] pin_lvl;
        logic pulse_lvl;
    } otfs_state_s;

    otfs_state_s st_q;
    otfs_state_s st_d;

    // ------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------
    function automatic logic otfs_source(input logic [15:0] code, input otfs_pkg::otfs_status_s s,
                                         input logic cyc_pulse);
        logic on;
        on = 1'b0;
        if (code <= otfs_pkg::MAX_SEL_CODE) begin
            case (otfs_pkg::otfs_src_e'(code[5:0]))
                otfs_pkg::SRC_NONE: on = 1'b0;
                otfs_pkg::SRC_FREQ_REACHED: on = s.freq_reached;
                otfs_pkg::SRC_FREQ_LEVEL: on = s.frequency_level_detect;
                otfs_pkg::SRC_FAULT_STOP: on = s.fault_stop;
                otfs_pkg::SRC_MOTOR_OVL: on = s.motor_overload_warn;
                otfs_pkg::SRC_DRIVE_OVL: on = s.drive_overload_warn;
                otfs_pkg::SRC_ZERO_RUN: on = s.running & s.zero_frequency;
                otfs_pkg::SRC_ZERO_ALL: on = s.zero_frequency | ~s.running;
                otfs_pkg::SRC_UPPER: on = s.upper_limit_reached;
                otfs_pkg::SRC_LOWER: on = s.running & s.lower_limit_reached;
                otfs_pkg::SRC_SET_COUNT: on = s.set_count_reached;
                otfs_pkg::SRC_DES_COUNT: on = s.designated_count_reached;
                otfs_pkg::SRC_LENGTH: on = s.length_exceeded;
                otfs_pkg::SRC_CYCLE_DONE: on = cyc_pulse;
                otfs_pkg::SRC_RUN_TIME: on = s.run_time_exceeded;
                otfs_pkg::SRC_FREQ_LIMITED: begin
                    on = s.command_beyond_limit & (s.upper_limit_reached | s.lower_limit_reached);
                end
                otfs_pkg::SRC_TORQUE_LIMITED: on = s.speed_control & s.torque_at_limit;
                otfs_pkg::SRC_READY: on = s.power_stable & ~s.fault_present & ~s.running;
                otfs_pkg::SRC_RUNNING: on = s.running;
                otfs_pkg::SRC_ANALOG_CMP: on = s.analog_input_one > s.analog_input_two;
                otfs_pkg::SRC_UNDERVOLT: on = s.undervoltage;
                default: on = 1'b0;
            endcase
        end
        return on;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic setup;
    logic wr_acc;
    logic cyc_pulse;
    logic unit_tick;
    logic [3:0] raw;
    logic [7:0] idx;

    assign setup = PSEL & ~PENABLE;
    assign wr_acc = PSEL & PENABLE & PWRITE;
    assign cyc_pulse = st_q.pulse_cnt != 32'h0000_0000;
    assign unit_tick = st_q.unit_cnt == 32'(DELAY_UNIT_CYC - 1);

    always_comb begin
        st_d = st_q;
        idx = 8'h00;

        // Register writes land at the access phase; only the low two lanes hold bits.
        if (wr_acc) begin
            if (PADDR == otfs_pkg::OFS_FAST_MODE) begin
                if (PSTRB[0]) begin
                    st_d.fast_mode = PWDATA[0];
                end
            end else if (PADDR >= otfs_pkg::OFS_SEL_BASE && PADDR < otfs_pkg::OFS_POLARITY
                         && PADDR[1:0] == 2'b00) begin
                idx = (PADDR - otfs_pkg::OFS_SEL_BASE) >> 2;
                if (PSTRB[0]) begin
                    st_d.sel[idx[1:0]][7:0] = PWDATA[7:0];
                end
                if (PSTRB[1]) begin
                    st_d.sel[idx[1:0]][15:8] = PWDATA[15:8];
                end
            end else if (PADDR == otfs_pkg::OFS_POLARITY) begin
                if (PSTRB[0]) begin
                    st_d.polarity = PWDATA[3:0];
                end
            end else if (PADDR >= otfs_pkg::OFS_DLY_BASE && PADDR < otfs_pkg::OFS_STATUS
                         && PADDR[1:0] == 2'b00) begin
                idx = (PADDR - otfs_pkg::OFS_DLY_BASE) >> 2;
                if (PSTRB[0]) begin
                    st_d.delay[idx[1:0]][7:0] = PWDATA[7:0];
                end
                if (PSTRB[1]) begin
                    st_d.delay[idx[1:0]][15:8] = PWDATA[15:8];
                end
            end
        end

        // Read data and the error answer are prepared in the setup phase.
        if (setup) begin
            st_d.err = 1'b0;
            st_d.rdata = 32'h0000_0000;
            if (PADDR[1:0] != 2'b00) begin
                st_d.err = 1'b1;
            end else if (PADDR == otfs_pkg::OFS_FAST_MODE) begin
                st_d.rdata = {31'h0000_0000, st_q.fast_mode};
            end else if (PADDR >= otfs_pkg::OFS_SEL_BASE && PADDR < otfs_pkg::OFS_POLARITY) begin
                idx = (PADDR - otfs_pkg::OFS_SEL_BASE) >> 2;
                st_d.rdata = {16'h0000, st_q.sel[idx[1:0]]};
            end else if (PADDR == otfs_pkg::OFS_POLARITY) begin
                st_d.rdata = {28'h000_0000, st_q.polarity};
            end else if (PADDR >= otfs_pkg::OFS_DLY_BASE && PADDR < otfs_pkg::OFS_STATUS) begin
                idx = (PADDR - otfs_pkg::OFS_DLY_BASE) >> 2;
                st_d.rdata = {16'h0000, st_q.delay[idx[1:0]]};
            end else if (PADDR == otfs_pkg::OFS_STATUS) begin
                st_d.rdata = {23'h00_0000, cyc_pulse, st_q.pin_lvl, st_q.active};
            end else begin
                st_d.err = 1'b1;
            end
        end

        // A new cycle event restarts the pulse, so back-to-back cycles stretch it.
        if (STATUS.cycle_done) begin
            st_d.pulse_cnt = 32'(CYCLE_PULSE_CYC);
        end else if (cyc_pulse) begin
            st_d.pulse_cnt = st_q.pulse_cnt - 32'h0000_0001;
        end

        // Shared tenth-of-a-second time base for the output delays.
        st_d.unit_cnt = unit_tick ? 32'h0000_0000 : st_q.unit_cnt + 32'h0000_0001;

        // A change must persist for the full delay; a bounce back restarts it.
        for (int t = 0; t < otfs_pkg::NUM_TERM; t++) begin
            raw[t] = otfs_source(st_q.sel[t], STATUS, cyc_pulse);
            if (raw[t] == st_q.active[t]) begin
                st_d.elapsed[t] = 16'h0000;
            end else if (st_q.elapsed[t] >= st_q.delay[t]) begin
                st_d.active[t] = raw[t];
                st_d.elapsed[t] = 16'h0000;
            end else if (unit_tick) begin
                st_d.elapsed[t] = st_q.elapsed[t] + 16'h0001;
            end
            st_d.pin_lvl[t] = st_q.active[t] ^ st_q.polarity[t];
        end

        st_d.pulse_lvl = PULSE_TRAIN;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            st_q <= '0;
            st_q.fast_mode <= otfs_pkg::RST_FAST_MODE[0];
            st_q.sel[0] <= otfs_pkg::RST_SEL_FAST;
            st_q.sel[1] <= otfs_pkg::RST_SEL_RELAY1;
            st_q.sel[2] <= otfs_pkg::RST_SEL_RELAY2;
            st_q.sel[3] <= otfs_pkg::RST_SEL_OC;
            st_q.polarity <= otfs_pkg::RST_POLARITY;
            for (int t = 0; t < otfs_pkg::NUM_TERM; t++) begin
                st_q.delay[t] <= otfs_pkg::RST_DELAY;
            end
        end else if (CE) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PREADY = 1'b1;
    assign PRDATA = st_q.rdata;
    assign PSLVERR = PSEL & PENABLE & st_q.err;

    always_comb begin
        PINS.fast_output_terminal = st_q.fast_mode ? st_q.pin_lvl[0] : st_q.pulse_lvl;
        PINS.first_relay = st_q.pin_lvl[1];
        PINS.second_relay = st_q.pin_lvl[2];
        PINS.open_collector_output = st_q.pin_lvl[3];
    end

endmodule

`default_nettype wire

// file: testbench/otfs_properties.sv
/* Port checker for otfs_top, bound into every instance of it.
   Assumes otfs_pkg is compiled first and the bus is APB. */
`timescale 1ns/10ps
`default_nettype none
module otfs_properties (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic PULSE_TRAIN,
    input wire otfs_pkg::otfs_pins_s PINS
);
    logic mode_q;
    wire logic bad_a = PADDR[1:0] != 2'b00 || PADDR > otfs_pkg::OFS_STATUS;
    // Shadow of the fast terminal mode bit, followed from bus writes.
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            mode_q <= 1'b0;
        end else if (CE && PSEL && PENABLE && PWRITE && PADDR == otfs_pkg::OFS_FAST_MODE && PSTRB[0]) begin
            mode_q <= PWDATA[0];
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    a_reset_clears_pins: assert property ($past(!NRST && CE) |-> PINS == '0)
        else $error("pins not clear after reset");
    a_pulse_follows_train: assert property ($past(NRST && CE) && !mode_q
        |-> PINS.fast_output_terminal == $past(PULSE_TRAIN)) else $error("pulse mode pin wrong");
    a_bad_addr_err: assert property (PSEL && PENABLE && !PWRITE && bad_a && $past(CE && PSEL && !PENABLE)
        |-> PSLVERR && PRDATA == '0) else $error("bad address not refused");
    a_good_addr_ok: assert property (PSEL && PENABLE && !bad_a && $past(CE && PSEL && !PENABLE) |-> !PSLVERR)
        else $error("good address refused");
    a_err_only_access: assert property (PSLVERR |-> PSEL && PENABLE && PREADY)
        else $error("error outside access phase");
    a_read_upper_zero: assert property (PSEL && PENABLE && !PWRITE |-> PRDATA[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_rdata_stands: assert property (PSEL && PENABLE |=> $stable(PRDATA))
        else $error("read data moved");
    a_frozen_pins: assert property (!CE |=> $stable(PINS))
        else $error("pins moved while clock enable low");
    c_err_seen: cover property (PSEL && PENABLE && PSLVERR);
    c_switch_on: cover property (mode_q && PINS.fast_output_terminal);
    c_oc_rise: cover property ($rose(PINS.open_collector_output));
endmodule
bind otfs_top otfs_properties u_props (.CLOCK(CLOCK), .NRST(NRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PULSE_TRAIN(PULSE_TRAIN), .PINS(PINS));
`default_nettype wire

// file: testbench/otfs_load_model.sv
/* Loads on the output terminals: relays and open-collector inputs.
   Assumes a pin at 1 is connected to common and powers its load. */
`timescale 1ns/10ps
`default_nettype none
module otfs_load_model (
    input wire logic clk,
    input wire otfs_pkg::otfs_pins_s pins,
    output logic [15:0] pulse_count = 16'h0000,
    output logic [3:0] load_on
);
    logic fast_q = 1'b0;
    assign load_on = pins;
    // Counts rising edges seen on the fast terminal's load.
    always @(posedge clk) begin
        fast_q <= pins.fast_output_terminal;
        if (pins.fast_output_terminal === 1'b1 && fast_q === 1'b0) pulse_count <= pulse_count + 16'h0001;
    end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
/* Self-checking bench of otfs_top with the load model on its pins.
   Assumes otfs_pkg, otfs_top, the checker and the load model are compiled. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int U = 4;
    localparam int P = 20;
    logic CLOCK = 1'b0, NRST = 1'b0, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PULSE_TRAIN = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd, ent;
    logic [3:0] PSTRB = 4'h0, load_on;
    logic PREADY, PSLVERR, er;
    logic [15:0] pulse_count, c0;
    otfs_pkg::otfs_status_s st = '0;
    otfs_pkg::otfs_pins_s PINS;
    int err_count = 0, checks_done = 0, n;
    wire logic [31:0] oc = {31'h0, PINS.open_collector_output};
    wire logic [31:0] fast = {31'h0, PINS.fast_output_terminal};
    // Rows: code, condition bits from freq_reached down to undervoltage, then a nibble:
    // bit 0 is the expected pin, bit 1 sets analog input one to 1, bit 3 makes it negative.
    logic [31:0] tab [31] = '{
        32'h00fff7f2, 32'h01800001, 32'h02400001, 32'h03200001, 32'h04100001,
        32'h05080001, 32'h06060001, 32'h06020000, 32'h07020001, 32'h08010001,
        32'h09048001, 32'h09008000, 32'h0a004001, 32'h0b002001, 32'h0c001001,
        32'h0e000401, 32'h0f010201, 32'h0f000200, 32'h10000181, 32'h10000080,
        32'h11000041, 32'h11000060, 32'h12060001, 32'h13000003, 32'h13000000,
        32'h13000008, 32'h14000011, 32'h15fff7f2, 32'h17fff7f2, 32'h28fff7f2,
        32'h3ffff7f2};
    otfs_top #(.DELAY_UNIT_CYC(U), .CYCLE_PULSE_CYC(P)) u_dut (.CLOCK(CLOCK), .NRST(NRST), .CE(CE), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .STATUS(st), .PULSE_TRAIN(PULSE_TRAIN), .PINS(PINS));
    otfs_load_model u_load (.clk(CLOCK), .pins(PINS), .pulse_count(pulse_count), .load_on(load_on));
    always #5 CLOCK = ~CLOCK;
    task automatic tick(input int k);
        repeat (k) @(posedge CLOCK);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= s;
        tick(1);
        PENABLE <= 1'b1;
        do begin
            tick(1);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        tick(1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        tick(20000);
        err_count++;
        conclude();
    end
    initial begin
        tick(6);
        NRST <= 1'b1;
        tick(1);
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, 4'hf);
            chk(rd, {30'h0, i == 2, i == 4});
        end
        apb(1'b0, 8'h2c, 32'h0, 4'hf);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, 8'h0e, 32'h5, 4'hf);
        chk(32'(er), 32'h1);
        apb(1'b1, 8'h0c, 32'hffff1234, 4'h2);
        apb(1'b0, 8'h0c, 32'h0, 4'hf);
        chk(rd, 32'h1200);
        apb(1'b1, 8'h0c, 32'h0, 4'hf);
        st[51:32] <= 20'hc0000;
        tick(4);
        chk(32'(load_on), 32'h5);
        apb(1'b0, 8'h28, 32'h0, 4'hf);
        chk(rd, 32'h0000_00aa);
        foreach (tab[i]) begin
            ent = tab[i];
            apb(1'b1, 8'h10, {24'h0, ent[31:24]}, 4'hf);
            st <= {ent[23:4], ent[3], 14'h0, ent[1], 16'h0};
            tick(4);
            chk(oc, {31'h0, ent[0]});
            st <= '0;
            tick(4);
            chk(oc, {31'h0, ent[31:24] == 8'h07});
        end
        apb(1'b1, 8'h10, 32'hd, 4'hf);
        st.cycle_done <= 1'b1;
        tick(1);
        st.cycle_done <= 1'b0;
        n = 0;
        repeat (60) begin
            tick(1);
            if (PINS.open_collector_output === 1'b1) n++;
        end
        chk(32'(n), 32'(P));
        apb(1'b1, 8'h10, 32'h3, 4'hf);
        apb(1'b1, 8'h24, 32'h2, 4'hf);
        st.fault_stop <= 1'b1;
        tick(5);
        st.fault_stop <= 1'b0;
        tick(20);
        chk(oc, 32'h0);
        st.fault_stop <= 1'b1;
        tick(2 * U - 1);
        chk(oc, 32'h0);
        tick(U + 4);
        chk(oc, 32'h1);
        CE <= 1'b0;
        tick(3);
        CE <= 1'b1;
        apb(1'b1, 8'h24, 32'h0, 4'hf);
        apb(1'b1, 8'h14, 32'h8, 4'hf);
        st.fault_stop <= 1'b0;
        tick(4);
        chk(oc, 32'h1);
        st.fault_stop <= 1'b1;
        tick(4);
        chk(oc, 32'h0);
        c0 = pulse_count;
        repeat (5) begin
            PULSE_TRAIN <= 1'b1;
            tick(2);
            PULSE_TRAIN <= 1'b0;
            tick(2);
        end
        tick(2);
        chk(32'(pulse_count), 32'(c0) + 32'h5);
        apb(1'b1, 8'h00, 32'h1, 4'hf);
        apb(1'b1, 8'h04, 32'h3, 4'hf);
        tick(4);
        chk(fast, 32'h1);
        PULSE_TRAIN <= 1'b1;
        st.fault_stop <= 1'b0;
        tick(4);
        chk(fast, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
